// *** pkg/status_word_pkg.sv ***
// Package with register map, field layout and reset values of the CPU status word block.
package status_word_pkg;
    // APB byte addresses of the registers.
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CORE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_INT_CTRL1 = 8'h08;
    localparam logic [7:0] ADDR_PRIORITY = 8'h0C;
    // Field positions inside the status word.
    localparam int POS_CARRY = 0;
    localparam int POS_ZERO = 1;
    localparam int POS_OVF = 2;
    localparam int POS_NEG = 3;
    localparam int POS_LOOP = 4;
    localparam int POS_PRIO_LO = 5;
    localparam int POS_PRIO_HI = 7;
    localparam int POS_COMBINED_CLIP = 13;
    localparam int POS_SECOND_CLIP = 14;
    localparam int POS_FIRST_CLIP = 15;
    // Fourth priority bit in the core control word and nesting disable bit.
    localparam int POS_LEVEL_BIT3 = 3;
    localparam int POS_NEST_DIS = 15;
    // Reset values.
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [15:0] RST_CORE_CTRL = 16'h0000;
    localparam logic [15:0] RST_INT_CTRL1 = 16'h0000;
    // Code in the priority field that disables user interrupts.
    localparam logic [2:0] PRIO_ALL_OFF = 3'h7;
    // Read data for an unmapped address.
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// *** rtl/alu_flag_calc.sv ***
`timescale 1ns/1ns
// Combinational derivation of the arithmetic result flags.
module alu_flag_calc #(
    parameter int WIDTH = 16
) (
    // Operands and sum from the arithmetic unit.
    input wire logic [WIDTH-1:0] opA,
    input wire logic [WIDTH-1:0] opB,
    input wire logic [WIDTH:0] sumFull,
    input wire logic isSub,
    // Derived flags.
    output logic negFlag,
    output logic ovfFlag,
    output logic zeroResult,
    output logic carryFlag
);
    logic [WIDTH-1:0] bEff;
    initial begin
        if (WIDTH < 2) $error("WIDTH must be at least 2");
    end
    // The flags follow the sign, the sign change and the carry of the result.
    always_comb begin
        bEff = isSub ? ~opB : opB;
        negFlag = sumFull[WIDTH-1]; // [RL7]
        ovfFlag = (opA[WIDTH-1] == bEff[WIDTH-1]) &&
                  (sumFull[WIDTH-1] != opA[WIDTH-1]); // [RL8]
        zeroResult = (sumFull[WIDTH-1:0] == '0);
        carryFlag = sumFull[WIDTH]; // [RL10]
    end
endmodule

// *** rtl/apb_word_port.sv ***
`timescale 1ns/1ns
// APB slave front end that turns accesses into one-cycle strobes.
module apb_word_port (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // Strobes to the register file.
    output logic wrStrobe,
    output logic rdStrobe,
    output logic [7:0] accAddr,
    output logic [15:0] wrData,
    output logic [1:0] wrLanes
);
    // The slave answers in the first access cycle, so every access completes there.
    always_comb begin
        wrStrobe = psel && penable && pwrite;
        rdStrobe = psel && !penable && !pwrite;
        accAddr = paddr;
        wrData = pwdata[15:0];
        wrLanes = pstrb[1:0];
    end
endmodule

// *** rtl/cpu_status_flags.sv ***
`timescale 1ns/1ns
// CPU status word with priority level, loop flag, result flags and clip bits.
//
// Contract
// [RL1] The priority field sits in bits 7 to 5 and code 7 disables user interrupts.
// [RL2] The full priority level is the field with the core control bit 3 above it.
// [RL3] With that fourth bit set the field stands for levels 8 to 15.
// [RL4] User interrupts are blocked whenever the fourth priority bit is set.
// [RL5] Writes to the priority field are ignored while the nesting disable bit is one.
// [RL6] Bit 4 is set while a repeat loop runs and clear otherwise.
// [RL7] Bit 3 is set for a negative result and cleared otherwise.
// [RL8] Bit 2 is set on signed overflow and cleared otherwise.
// [RL9] Bit 1 holds until an affecting operation, which clears it on a non-zero result.
// [RL10] Bit 0 is set when a carry leaves the top bit of the result.
// [RL11] Both clip bits change by a direct write or by writing zero to the combined bit.
// [RL12] Software should not change the clip bits with single-bit read-modify-write.
// [RL13] Reads give the whole word, and a same-cycle hardware update beats a write.
module cpu_status_flags
    import status_word_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Arithmetic unit update.
    input wire logic aluValid,
    input wire logic aluSub,
    input wire logic [WIDTH-1:0] aluOpA,
    input wire logic [WIDTH-1:0] aluOpB,
    input wire logic [WIDTH:0] aluSum,
    input wire logic aluZeroAffect,
    // Repeat loop, interrupt logic and saturation events.
    input wire logic loopRunning,
    input wire logic prioLoad,
    input wire logic [2:0] prioLoadValue,
    input wire logic clip1Set,
    input wire logic clip2Set,
    // Status outputs.
    output logic [15:0] statusWord,
    output logic [3:0] cpuPriority,
    output logic userIntBlocked
);
    // Stored register fields.
    typedef struct packed {
        logic [2:0] prio;
        logic loopAct;
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
        logic clip1;
        logic clip2;
        logic levelBit3;
        logic nestDis;
        // Registered read data and output copies.
        logic [31:0] rdData;
        logic [15:0] statusOut;
        logic [3:0] prioOut;
        logic blockedOut;
        // Registered bus answer.
        logic readyOut;
        logic errOut;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Strobes from the bus front end.
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] accAddr;
    logic [15:0] wrData;
    logic [1:0] wrLanes;
    // Flags derived from the arithmetic result.
    logic negFlag;
    logic ovfFlag;
    logic zeroResult;
    logic carryFlag;

    // Refuses operand widths that the flag logic cannot serve.
    initial begin
        if (WIDTH < 2 || WIDTH > 32) $error("WIDTH out of range");
    end

    // Packs the stored fields into the visible status word.
    function automatic logic [15:0] pack_word(input state_t s);
        logic [15:0] w;
        // Bits that hold no field read as their reset value.
        w = RST_STATUS;
        w[POS_CARRY] = s.carry;
        w[POS_ZERO] = s.zero;
        w[POS_OVF] = s.ovf;
        w[POS_NEG] = s.neg;
        w[POS_LOOP] = s.loopAct;
        w[POS_PRIO_HI:POS_PRIO_LO] = s.prio; // [RL1]
        // The combined clip bit is not stored; it reads as either clip bit.
        w[POS_COMBINED_CLIP] = s.clip1 | s.clip2;
        w[POS_SECOND_CLIP] = s.clip2;
        w[POS_FIRST_CLIP] = s.clip1;
        return w;
    endfunction

    // Forms the full four-bit priority level from the field and bit 3.
    // With the top bit set the field stands for levels 8 to 15.
    function automatic logic [3:0] full_level(input logic b3, input logic [2:0] f);
        return {b3, f}; // [RL2] [RL3]
    endfunction

    // Bus front end that turns each access into one strobe.
    apb_word_port u_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .accAddr(accAddr),
        .wrData(wrData),
        .wrLanes(wrLanes)
    );

    // Flag derivation from the operands and the sum.
    alu_flag_calc #(
        .WIDTH(WIDTH)
    ) u_flags (
        .opA(aluOpA),
        .opB(aluOpB),
        .sumFull(aluSum),
        .isSub(aluSub),
        .negFlag(negFlag),
        .ovfFlag(ovfFlag),
        .zeroResult(zeroResult),
        .carryFlag(carryFlag)
    );

    // Software writes first, hardware updates after so that they win.
    always_comb begin
        // Every field holds unless something below changes it.
        st_nxt = st_r;

        // Software write to the addressed register.
        if (wrStrobe) begin
            case (accAddr)
                ADDR_STATUS: begin
                    // Low lane: result flags and, unless locked, the priority field.
                    if (wrLanes[0]) begin
                        st_nxt.carry = wrData[POS_CARRY];
                        st_nxt.zero = wrData[POS_ZERO];
                        st_nxt.ovf = wrData[POS_OVF];
                        st_nxt.neg = wrData[POS_NEG];
                        if (!st_r.nestDis) begin
                            st_nxt.prio = wrData[POS_PRIO_HI:POS_PRIO_LO]; // [RL5]
                        end
                    end
                    // High lane: direct clip bits, then a cleared combined bit wipes both.
                    if (wrLanes[1]) begin
                        st_nxt.clip1 = wrData[POS_FIRST_CLIP]; // [RL11]
                        st_nxt.clip2 = wrData[POS_SECOND_CLIP]; // [RL11]
                        if (!wrData[POS_COMBINED_CLIP]) begin
                            st_nxt.clip1 = 1'b0; // [RL11]
                            st_nxt.clip2 = 1'b0; // [RL11]
                        end
                    end
                end
                ADDR_CORE_CTRL: begin
                    // Core control keeps only the fourth priority bit.
                    if (wrLanes[0]) begin
                        st_nxt.levelBit3 = wrData[POS_LEVEL_BIT3];
                    end
                end
                ADDR_INT_CTRL1: begin
                    // Only the nesting disable bit is kept; it locks the priority field.
                    if (wrLanes[1]) begin
                        st_nxt.nestDis = wrData[POS_NEST_DIS];
                    end
                end
                default: begin
                    // Unmapped addresses are ignored.
                end
            endcase
        end

        // Hardware updates override a write in the same cycle.
        st_nxt.loopAct = loopRunning; // [RL6] [RL13]

        // An arithmetic result replaces the result flags; zero only ever clears.
        if (aluValid) begin
            st_nxt.neg = negFlag; // [RL7] [RL13]
            st_nxt.ovf = ovfFlag; // [RL8]
            st_nxt.carry = carryFlag; // [RL10]
            // A zero result leaves the flag as it was; only software sets it.
            if (aluZeroAffect && !zeroResult) begin
                st_nxt.zero = 1'b0; // [RL9]
            end
        end

        // The interrupt logic loads the field even while software is locked out.
        if (prioLoad) begin
            st_nxt.prio = prioLoadValue;
        end

        // Saturation events set the clip bits after any write, so the event wins.
        if (clip1Set) begin
            st_nxt.clip1 = 1'b1;
        end
        if (clip2Set) begin
            st_nxt.clip2 = 1'b1;
        end

        // Read data is captured in setup so it is valid in the access cycle.
        if (rdStrobe) begin
            case (accAddr)
                ADDR_STATUS: st_nxt.rdData = {16'h0000, pack_word(st_r)}; // [RL13]
                ADDR_CORE_CTRL: st_nxt.rdData = {28'h0000000, st_r.levelBit3, 3'h0};
                ADDR_INT_CTRL1: st_nxt.rdData = {16'h0000, st_r.nestDis, 15'h0000};
                ADDR_PRIORITY: st_nxt.rdData = {27'h0000000,
                    st_r.blockedOut, full_level(st_r.levelBit3, st_r.prio)};
                default: st_nxt.rdData = RD_UNMAPPED;
            endcase
        end

        // Every access completes in its first access cycle without error.
        st_nxt.readyOut = 1'b1;
        st_nxt.errOut = 1'b0;

        // Output copies come from the next state so they stand together with it.
        st_nxt.statusOut = pack_word(st_nxt);
        st_nxt.prioOut = full_level(st_nxt.levelBit3, st_nxt.prio);
        st_nxt.blockedOut = st_nxt.levelBit3 || (st_nxt.prio == PRIO_ALL_OFF); // [RL4] [RL1]
    end

    // State register with synchronous reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // Reset loads the reset value of every field.
            st_r <= '0;
            st_r.readyOut <= 1'b1;
            st_r.prio <= RST_STATUS[POS_PRIO_HI:POS_PRIO_LO];
            st_r.levelBit3 <= RST_CORE_CTRL[POS_LEVEL_BIT3];
            st_r.nestDis <= RST_INT_CTRL1[POS_NEST_DIS];
            st_r.rdData <= RD_UNMAPPED;
            st_r.statusOut <= RST_STATUS;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    always_comb begin
        prdata = st_r.rdData;
        pready = st_r.readyOut;
        pslverr = st_r.errOut;
        statusWord = st_r.statusOut;
        cpuPriority = st_r.prioOut;
        userIntBlocked = st_r.blockedOut;
    end
endmodule

// *** tb/status_props_properties.sv ***
// Port checks of the CPU status word block.
`timescale 1ns/1ns
module status_props
    import status_word_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    // Arithmetic unit and loop.
    input wire logic aluValid,
    input wire logic aluSub,
    input wire logic aluZeroAffect,
    input wire logic loopRunning,
    input wire logic [WIDTH-1:0] aluOpA,
    input wire logic [WIDTH-1:0] aluOpB,
    input wire logic [WIDTH:0] aluSum,
    // Status outputs.
    input wire logic [15:0] statusWord,
    input wire logic [3:0] cpuPriority,
    input wire logic userIntBlocked
);
    // Signed overflow expected from the sign bits.
    logic ovfExp;
    assign ovfExp = (aluSub ~^ (aluOpA[WIDTH-1] ^ aluOpB[WIDTH-1]))
        & (aluOpA[WIDTH-1] ^ aluSum[WIDTH-1]);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_prio_field: assert property (cpuPriority[2:0] == statusWord[7:5])
        else $error("level field");
    chk_block_high: assert property (cpuPriority[3] |-> userIntBlocked)
        else $error("high block");
    chk_block_seven: assert property (statusWord[7:5] == 3'h7 |-> userIntBlocked)
        else $error("seven block");
    chk_loop_copy: assert property ($past(rst_n) |-> statusWord[4] == $past(loopRunning))
        else $error("loop flag");
    chk_neg_flag: assert property (aluValid |=> statusWord[3] == $past(aluSum[WIDTH-1]))
        else $error("neg flag");
    chk_ovf_flag: assert property (aluValid |=> statusWord[2] == $past(ovfExp))
        else $error("ovf flag");
    chk_carry_flag: assert property (aluValid |=> statusWord[0] == $past(aluSum[WIDTH]))
        else $error("carry flag");
    chk_zero_clear: assert property (aluValid && aluZeroAffect
        && aluSum[WIDTH-1:0] != '0 |=> !statusWord[1]) else $error("zero clear");
    chk_zero_hold: assert property (!(aluValid && aluZeroAffect)
        && !(psel && penable && pwrite) |=> $stable(statusWord[1])) else $error("zero hold");
    chk_clip_or: assert property (statusWord[13] == (statusWord[15] | statusWord[14]))
        else $error("clip or");
    chk_read_word: assert property (psel && !penable && !pwrite && paddr == ADDR_STATUS
        |=> prdata == {16'h0000, $past(statusWord)}) else $error("read word");
    cover property (aluValid && aluSub && aluSum[WIDTH]);
    cover property (cpuPriority == 4'hF && userIntBlocked);
    cover property (statusWord[15:13] == 3'h7);
endmodule

// *** tb/alu_model.sv ***
// Behavioural arithmetic unit feeding results to the status word.
`timescale 1ns/1ns
module alu_model #(parameter int WIDTH = 16) (
    // Clock.
    input wire logic mclk,
    // Result towards the status word.
    output logic aluValid, aluSub, aluZeroAffect,
    output logic [WIDTH-1:0] aluOpA, aluOpB,
    output logic [WIDTH:0] aluSum
);
    // Idle lines at time zero.
    initial begin
        {aluValid, aluSub, aluZeroAffect, aluOpA, aluOpB, aluSum} = '0;
    end
    // One result after gap idle cycles; afterwards operands and sum show their inverse, valid and zero-affect drop, aluSub holds.
    task automatic op(input logic s, input logic [WIDTH-1:0] a, b, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        aluValid <= 1'b1;
        aluSub <= s;
        aluZeroAffect <= 1'b1;
        aluOpA <= a;
        aluOpB <= b;
        aluSum <= {1'b0, a} + (s ? {1'b0, ~b} + 1'b1 : {1'b0, b});
        @(posedge mclk);
        aluValid <= 1'b0;
        aluZeroAffect <= 1'b0;
        aluOpA <= ~a;
        aluOpB <= ~b;
        aluSum <= ~aluSum;
    endtask
endmodule

// *** tb/cpu_status_flags_tb.sv ***
// Self-checking bench of the CPU status word block.
`timescale 1ns/1ns
module cpu_status_flags_tb;
    import status_word_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rdErr;
    logic [3:0] pstrb = 4'h3;
    logic loopRunning = 0, prioLoad = 0, clip1Set = 0, clip2Set = 0;
    logic aluValid, aluSub, aluZeroAffect, userIntBlocked;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] prioLoadValue = 3'h0;
    logic [15:0] aluOpA, aluOpB, statusWord;
    logic [16:0] aluSum;
    logic [3:0] cpuPriority;
    int errTotal = 0, cmpCount = 0;
    // Clock of 40 ns.
    initial forever #20 mclk = ~mclk;
    cpu_status_flags DUT(
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .aluValid(aluValid), .aluSub(aluSub), .aluOpA(aluOpA),
        .aluOpB(aluOpB), .aluSum(aluSum), .aluZeroAffect(aluZeroAffect),
        .loopRunning(loopRunning), .prioLoad(prioLoad), .prioLoadValue(prioLoadValue),
        .clip1Set(clip1Set), .clip2Set(clip2Set), .statusWord(statusWord),
        .cpuPriority(cpuPriority), .userIntBlocked(userIntBlocked));
    alu_model PARTNER(.mclk(mclk), .aluValid(aluValid), .aluSub(aluSub),
        .aluZeroAffect(aluZeroAffect), .aluOpA(aluOpA), .aluOpB(aluOpB), .aluSum(aluSum));
    task automatic check(input string nm, input logic [31:0] exp, got);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // APB access with the lanes currently set in pstrb; waits for pready, only the watchdog ends a wait.
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic t_reset;
        apb(0, ADDR_STATUS, 16'h0000);
        check("status", {16'h0000, RST_STATUS}, rd);
        check("error", 32'h0, {31'h0, rdErr});
        apb(1, 8'h10, 16'hFFFF);
        apb(0, 8'h10, 16'h0000);
        check("unmapped", RD_UNMAPPED, rd);
        check("word", {16'h0000, RST_STATUS}, {16'h0000, statusWord});
    endtask
    task automatic t_prio;
        logic b;
        for (int l = 0; l < 16; l++) begin
            apb(1, ADDR_CORE_CTRL, {12'h000, l[3], 3'h0});
            apb(1, ADDR_STATUS, {8'h00, l[2:0], 5'h00});
            apb(0, ADDR_PRIORITY, 16'h0000);
            b = l[3] | (l[2:0] == 3'h7);
            check("level", {27'h0, b, l[3:0]}, rd);
            check("port level", {28'h0, l[3:0]}, {28'h0, cpuPriority});
            check("block", {31'h0, b}, {31'h0, userIntBlocked});
        end
    endtask
    task automatic t_nest;
        apb(1, ADDR_CORE_CTRL, 16'h0000);
        apb(1, ADDR_INT_CTRL1, 16'h8000);
        apb(1, ADDR_STATUS, 16'h0060);
        check("locked", 32'h7, {29'h0, statusWord[7:5]});
        @(posedge mclk);
        prioLoad <= 1'b1;
        prioLoadValue <= 3'h2;
        @(posedge mclk);
        prioLoad <= 1'b0;
        @(negedge mclk);
        check("load", 32'h2, {29'h0, statusWord[7:5]});
        apb(1, ADDR_INT_CTRL1, 16'h0000);
        apb(1, ADDR_STATUS, 16'h00A0);
        check("unlocked", 32'h5, {29'h0, statusWord[7:5]});
    endtask
    task automatic t_alu;
        logic [32:0] ops [5] = '{33'h0_0000_0000, 33'h0_7FFF_0001, 33'h0_FFFF_0001,
            33'h1_0005_0007, 33'h1_8000_0001};
        logic [16:0] s;
        logic [31:0] e;
        logic v, z;
        apb(1, ADDR_STATUS, 16'h0002);
        z = 1'b1;
        for (int i = 0; i < 5; i++) begin
            PARTNER.op(ops[i][32], ops[i][31:16], ops[i][15:0], i);
            s = {1'b0, ops[i][31:16]} + (ops[i][32] ? {1'b0, ~ops[i][15:0]} + 17'h1
                : {1'b0, ops[i][15:0]});
            v = (ops[i][32] ~^ (ops[i][31] ^ ops[i][15])) & (ops[i][31] ^ s[15]);
            if (s[15:0] != 16'h0000) z = 1'b0;
            e = {28'h0, s[15], v, z, s[16]};
            @(negedge mclk);
            check("flags", e, {28'h0, statusWord[3:0]});
        end
    endtask
    task automatic t_loop;
        @(posedge mclk);
        loopRunning <= 1'b1;
        apb(1, ADDR_STATUS, 16'h0000);
        check("loop on", 32'h1, {31'h0, statusWord[4]});
        @(posedge mclk);
        loopRunning <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check("loop off", 32'h0, {31'h0, statusWord[4]});
    endtask
    task automatic t_clip;
        @(posedge mclk);
        clip1Set <= 1'b1;
        @(posedge mclk);
        clip1Set <= 1'b0;
        clip2Set <= 1'b1;
        @(posedge mclk);
        clip2Set <= 1'b0;
        @(negedge mclk);
        check("clip set", 32'h7, {29'h0, statusWord[15:13]});
        apb(1, ADDR_STATUS, 16'hC000);
        check("clip clear", 32'h0, {29'h0, statusWord[15:13]});
        apb(1, ADDR_STATUS, 16'h6000);
        check("clip write", 32'h3, {29'h0, statusWord[15:13]});
        @(posedge mclk);
        pstrb <= 4'h1;
        apb(1, ADDR_STATUS, 16'h0000);
        @(posedge mclk);
        pstrb <= 4'h3;
        check("clip lane", 32'h3, {29'h0, statusWord[15:13]});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after 20 reset cycles.
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_prio();
        t_nest();
        t_alu();
        t_loop();
        t_clip();
        end_of_test();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (5000) @(posedge mclk);
        errTotal++;
        end_of_test();
    end
endmodule
bind cpu_status_flags status_props #(.WIDTH(WIDTH)) props(
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .aluValid(aluValid), .aluSub(aluSub),
    .aluZeroAffect(aluZeroAffect), .loopRunning(loopRunning), .aluOpA(aluOpA),
    .aluOpB(aluOpB), .aluSum(aluSum), .statusWord(statusWord), .cpuPriority(cpuPriority),
    .userIntBlocked(userIntBlocked));
